// *** pcm_pkg.sv ***
// Constants, field layouts and carrier types for the port C pin mux block.
// Assumes a single 20 MHz system clock and a plain strobe register port.
package pcm_pkg;
	// ==============================================================
	// Register map
	localparam logic [1:0] PCM_OFS_LEVELS  = 2'h0; // Pin levels / latch
	localparam logic [1:0] PCM_OFS_LATCH   = 2'h1; // Output latch
	localparam logic [1:0] PCM_OFS_DIR     = 2'h2; // Direction
	localparam logic [1:0] PCM_OFS_USBCTL  = 2'h3; // USB control
	// ==============================================================
	// Field layouts
	localparam int PCM_USB_EN_BIT = 3;              // Module enable bit
	localparam logic [7:0] PCM_IMPL_MASK  = 8'hF7;  // Pin 3 absent
	localparam logic [7:0] PCM_LATCH_MASK = 8'hC7;  // No bits 3..5
	localparam logic [7:0] PCM_USBC_MASK  = 8'h7E;  // Bits 0, 7 absent
	// ==============================================================
	// Reset values
	localparam logic [7:0] PCM_DIR_RST    = 8'hC7;  // All inputs
	localparam logic [7:0] PCM_LATCH_RST  = 8'h00;
	localparam logic [7:0] PCM_USBC_RST   = 8'h00;

	// Register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pcm_req_t;

	// Peripheral overrides towards the pins
	typedef struct packed {
		logic tosc_en;      // Timer oscillator enabled
		logic cc2_on;       // Unit two active
		logic cc2_pin_sel;  // 1: pin 1, 0: alternate
		logic cc2_out;
		logic cc1_on;       // Unit one output mode
		logic cc1_out;
		logic pwma_on;      // Enhanced PWM channel A
		logic pwma_out;
		logic pwma_shut_tri;// Shutdown tri-state request
		logic xcvr_ext;     // External transceiver selected
		logic xcvr_oe;
		logic xcvr_int_on;  // On-chip transceiver enabled
		logic usb_drive;    // USB module driving D lines
		logic usb_dm;
		logic usb_dp;
		logic ser_on;       // Serial unit enabled
		logic ser_sync;     // Synchronous mode
		logic ser_tx;       // Async tx or sync clock out
		logic ser_sync_dout;// Sync data out phase
		logic ser_dt;
		logic spi_on;
		logic spi_sdo;
	} pcm_periph_t;

	// Pin levels back to peripherals
	typedef struct packed {
		logic tosc_in;
		logic tcount;
		logic cc2_cap;
		logic cc1_cap;
		logic xcvr_minus_input;
		logic xcvr_plus_input;
		logic usb_dm_in;
		logic usb_dp_in;
		logic ser_clk_in;
		logic ser_rx;
	} pcm_feed_t;
endpackage : pcm_pkg

// *** pcm_pin_cell.sv ***
// One generic port pin: latch versus override, direction resolution.
// Assumes the override controls are already decoded by the port.
`timescale 1ns/1ns
`default_nettype none
module pcm_pin_cell (
	input  wire logic latch_bit,  // Port latch value
	input  wire logic dir_bit,    // Stored direction, 1 = input
	input  wire logic ovr_data,   // Take peripheral data over latch
	input  wire logic ovr_val,    // Peripheral data value
	input  wire logic force_off,  // Analog or tristate, no driver
	input  wire logic force_out,  // Peripheral forces output
	output var  logic drive_val,
	output var  logic drive_en
);
	// ==============================================================
	// Driver resolution
	always_comb begin
		drive_val = ovr_data ? ovr_val : latch_bit;
		// Forced off wins, forced output next, else direction
		drive_en  = !force_off && (force_out || !dir_bit);
	end
endmodule : pcm_pin_cell
`default_nettype wire

// *** pcm_port_c.sv ***
// Port C pin multiplexer: registers, pin drivers and input sampling.
// Assumes pins already synchronous to clk_sys; peripherals outside.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pcm_port_c (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire pcm_pkg::pcm_req_t req,
	output var  logic [7:0]        rdata_q,
	input  wire pcm_pkg::pcm_periph_t per,
	output var  pcm_pkg::pcm_feed_t   feed_q,
	input  wire logic [7:0]        pin_i,
	output var  logic [7:0]        pin_o_q,
	output var  logic [7:0]        pin_oe_q,
	output var  logic              usb_module_enable_q
);
	import pcm_pkg::*;

	// ==============================================================
	// State
	logic [7:0] latch_q, latch_d;   // Output latch
	logic [7:0] dir_q, dir_d;       // Stored direction
	logic [7:0] usbc_q, usbc_d;     // USB control image
	logic [7:0] rdata_d;
	logic [7:0] pin_o_d, pin_oe_d;
	pcm_feed_t  feed_d;
	logic [7:0] cell_val, cell_en;  // From generic cells
	logic [7:0] ovr_data, ovr_val, f_off, f_out;
	logic       usb_any;            // USB or on-chip transceiver
	logic       cc2_here;           // Unit two mapped to pin 1
	logic [7:0] levels;             // Digital port read view

	// Masking helper, used on every register write and on the levels view
	function automatic logic [7:0] pcm_mask(input logic [7:0] v,
		input logic [7:0] m);
		pcm_mask = v & m;
	endfunction : pcm_mask

	// ==============================================================
	// Override decode per pin
	always_comb begin
		usb_any  = usbc_q[PCM_USB_EN_BIT] || per.xcvr_int_on;
		cc2_here = per.cc2_on && per.cc2_pin_sel;
		ovr_data = 8'h00;
		ovr_val  = 8'h00;
		f_off    = 8'h00;
		f_out    = 8'h00;
		// Pin 0: oscillator removes digital I/O
		f_off[0] = per.tosc_en;
		// Pin 1: oscillator, transceiver enable, unit two
		if (per.tosc_en) begin
			f_off[1] = 1'b1;
		end else if (per.xcvr_ext) begin
			ovr_data[1] = 1'b1;
			ovr_val[1]  = per.xcvr_oe;
			f_out[1]    = 1'b1;
		end else if (cc2_here) begin
			ovr_data[1] = 1'b1;
			ovr_val[1]  = per.cc2_out;
		end
		// Pin 2: PWM channel A first, then unit one compare
		if (per.pwma_on) begin
			ovr_data[2] = 1'b1;
			ovr_val[2]  = per.pwma_out;
			f_off[2]    = per.pwma_shut_tri;
		end else if (per.cc1_on) begin
			ovr_data[2] = 1'b1;
			ovr_val[2]  = per.cc1_out;
		end
		// Pin 3 does not exist
		f_off[3] = 1'b1;
		// Pins 4, 5: driven only by on-chip transceiver
		f_off[4] = !(per.xcvr_int_on && per.usb_drive && !per.xcvr_ext);
		f_off[5] = f_off[4];
		f_out[4] = 1'b1;
		f_out[5] = 1'b1;
		ovr_data[5:4] = 2'b11;
		ovr_val[4] = per.usb_dm;
		ovr_val[5] = per.usb_dp;
		// Pin 6: transmit or sync clock beats latch
		if (per.ser_on) begin
			ovr_data[6] = 1'b1;
			ovr_val[6]  = per.ser_tx;
		end
		// Pin 7: sync data out, then SPI, then latch
		if (per.ser_on && per.ser_sync && per.ser_sync_dout) begin
			ovr_data[7] = 1'b1;
			ovr_val[7]  = per.ser_dt;
			f_out[7]    = 1'b1;
		end else if (per.spi_on) begin
			ovr_data[7] = 1'b1;
			ovr_val[7]  = per.spi_sdo;
		end
	end

	// ==============================================================
	// Generic pin cells
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			pcm_pin_cell u_cell (
				.latch_bit (latch_q[gi]),
				.dir_bit   (dir_q[gi]),
				.ovr_data  (ovr_data[gi]),
				.ovr_val   (ovr_val[gi]),
				.force_off (f_off[gi]),
				.force_out (f_out[gi]),
				.drive_val (cell_val[gi]),
				.drive_en  (cell_en[gi])
			);
		end
	endgenerate

	// ==============================================================
	// Input paths and register next values
	always_comb begin
		// Pin 4, 5 have no direction bits; their enables come from f_off and f_out
		pin_oe_d = cell_en;
		pin_o_d  = cell_val;
		levels   = pin_i;
		levels[0] = pin_i[0] && !per.tosc_en;
		levels[1] = pin_i[1] && !per.tosc_en;
		// Pins 4, 5 read only in port mode; TTL buffers outside
		levels[5:4] = usb_any ? 2'b00 : pin_i[5:4];
		levels = pcm_mask(levels, PCM_IMPL_MASK);
		// Peripheral feeds
		feed_d = '0;
		feed_d.tosc_in  = pin_i[1];
		feed_d.tcount   = levels[0];
		feed_d.cc2_cap  = cc2_here && dir_q[1] && levels[1];
		feed_d.cc1_cap  = dir_q[2] && levels[2];
		feed_d.xcvr_minus_input = per.xcvr_ext && pin_i[4];
		feed_d.xcvr_plus_input  = per.xcvr_ext && pin_i[5];
		feed_d.usb_dm_in = per.xcvr_int_on && pin_i[4];
		feed_d.usb_dp_in = per.xcvr_int_on && pin_i[5];
		feed_d.ser_clk_in = per.ser_sync && dir_q[6] && pin_i[6];
		// Receive needs direction 1; sync receive relies on it too
		feed_d.ser_rx = dir_q[7] && pin_i[7];
		// Register writes: port and latch address both load latch
		latch_d = latch_q;
		dir_d   = dir_q;
		usbc_d  = usbc_q;
		if (req.wr) begin
			unique case (req.addr)
				PCM_OFS_LEVELS, PCM_OFS_LATCH: begin
					latch_d = pcm_mask(req.wdata, PCM_LATCH_MASK);
				end
				PCM_OFS_DIR: begin
					dir_d = pcm_mask(req.wdata, PCM_LATCH_MASK);
				end
				PCM_OFS_USBCTL: begin
					usbc_d = pcm_mask(req.wdata, PCM_USBC_MASK);
				end
			endcase
		end
		// Read data valid the cycle after the strobe only
		rdata_d = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				PCM_OFS_LEVELS: rdata_d = levels;
				PCM_OFS_LATCH:  rdata_d = latch_q;
				PCM_OFS_DIR:    rdata_d = dir_q;
				PCM_OFS_USBCTL: rdata_d = usbc_q;
			endcase
		end
	end

	// ==============================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			latch_q  <= PCM_LATCH_RST;
			dir_q    <= PCM_DIR_RST;
			usbc_q   <= PCM_USBC_RST;
			rdata_q  <= 8'h00;
			pin_o_q  <= 8'h00;
			pin_oe_q <= 8'h00;
			feed_q   <= '0;
			usb_module_enable_q <= 1'b0;
		end else begin
			latch_q  <= latch_d;
			dir_q    <= dir_d;
			usbc_q   <= usbc_d;
			rdata_q  <= rdata_d;
			pin_o_q  <= pin_o_d;
			pin_oe_q <= pin_oe_d;
			feed_q   <= feed_d;
			usb_module_enable_q <= usbc_d[PCM_USB_EN_BIT];
		end
	end
endmodule : pcm_port_c
`default_nettype wire

// *** pcm_port_c_chk.sv ***
// Port-level checks for the port C pin mux.
// Assumes pcm_pkg is compiled first; bound to every pcm_port_c.
`timescale 1ns/1ns
`default_nettype none
module pcm_port_c_chk (
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire pcm_pkg::pcm_req_t    req,
	input wire pcm_pkg::pcm_periph_t per,
	input wire logic [7:0]           pin_o_q,
	input wire logic [7:0]           pin_oe_q,
	input wire logic                 usb_module_enable_q
);
	import pcm_pkg::*;
	// ==============================================================
	// Overrides one and two edges back, so either latency passes
	pcm_periph_t p_q;
	pcm_periph_t pp_q;
	logic        r_q;
	logic        ok_q;
	always_ff @(posedge clk_sys) begin
		p_q  <= per;
		pp_q <= p_q;
		r_q  <= rst_n;
		ok_q <= r_q & rst_n;
	end
	// Steady overrides only, out of reset for two edges
	wire logic st = ok_q && (p_q == pp_q);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==============================================================
	// Pin ownership and USB enable copy
	a_reset_input: assert property (!$past(rst_n) |-> pin_oe_q == 8'h00)
		else $error("pin driven after reset");
	a_osc_owns: assert property (st && p_q.tosc_en |-> pin_oe_q[1:0] == 2'h0)
		else $error("pins 0 and 1 driven under oscillator");
	a_pwm_tristate: assert property (st && p_q.pwma_on && p_q.pwma_shut_tri
		|-> !pin_oe_q[2]) else $error("pin 2 driven in shutdown");
	a_ext_input: assert property (st && p_q.xcvr_ext |-> pin_oe_q[5:4] == 2'h0)
		else $error("pins 4 and 5 driven with external transceiver");
	a_port_input: assert property (st && !p_q.xcvr_int_on
		|-> pin_oe_q[5:4] == 2'h0) else $error("pins 4 and 5 driven in port mode");
	a_xcvr_enable: assert property (st && p_q.xcvr_ext && !p_q.tosc_en
		|-> pin_oe_q[1] && pin_o_q[1] == p_q.xcvr_oe)
		else $error("transceiver enable not on pin 1");
	a_usb_drive: assert property (st && p_q.xcvr_int_on && p_q.usb_drive
		&& !p_q.xcvr_ext |-> pin_oe_q[5:4] == 2'h3
		&& pin_o_q[5:4] == {p_q.usb_dp, p_q.usb_dm}) else $error("usb lines wrong");
	a_enable_copy: assert property (req.wr && req.addr == PCM_OFS_USBCTL
		&& req.wdata[PCM_USB_EN_BIT] |-> ##[1:2] usb_module_enable_q)
		else $error("usb enable copy not set");
endmodule : pcm_port_c_chk
bind pcm_port_c pcm_port_c_chk pcm_port_c_chk_inst (.clk_sys(clk_sys),
	.rst_n(rst_n), .req(req), .per(per), .pin_o_q(pin_o_q),
	.pin_oe_q(pin_oe_q), .usb_module_enable_q(usb_module_enable_q));
`default_nettype wire

// *** pcm_pins.sv ***
// Far side of port C: board wiring and outside drivers.
// Assumes the bench supplies the outside levels on ext.
`timescale 1ns/1ns
`default_nettype none
module pcm_pins (
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext,
	output var  logic [7:0] pin_i
);
	// Released pins show the outside level, never a stale drive
	always_comb pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule : pcm_pins
`default_nettype wire

// *** pcm_port_c_bench.sv ***
// Testbench for the port C pin mux: register tasks and pin checks.
// Assumes pcm_pkg, pcm_port_c, pcm_pins and the checker compiled.
`timescale 1ns/1ns
`default_nettype none
module pcm_port_c_bench;
	import pcm_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	pcm_req_t    req = '0;
	pcm_periph_t per = '0;
	pcm_feed_t   feed_q;
	logic [7:0]  rdata_q, pin_i, pin_o_q, pin_oe_q;
	logic [7:0]  ext = 8'hFF;
	logic        usb_module_enable_q;
	int          num_errors = 0;
	int          comparisons = 0;
	pcm_port_c pcm_port_c_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
		.rdata_q(rdata_q), .per(per), .feed_q(feed_q), .pin_i(pin_i),
		.pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q),
		.usb_module_enable_q(usb_module_enable_q));
	pcm_pins pcm_pins_inst (.pin_o(pin_o_q), .pin_oe(pin_oe_q), .ext(ext),
		.pin_i(pin_i));
	initial forever #25 clk_sys = ~clk_sys;
	// ==============================================================
	// Tasks
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// One-cycle strobes, released at the taking edge
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys) req.rd <= 1'b0;
		#1 chk("rdata", e, rdata_q);
	endtask : rd
	task setp(input pcm_periph_t v);
		@(posedge clk_sys) per <= v;
	endtask : setp
	// Let pins settle, then check every enable bit and the driven output bits only
	task pins(input logic [7:0] oe, input logic [7:0] o);
		repeat (3) @(posedge clk_sys);
		#1 chk("pin_oe", oe, pin_oe_q);
		chk("pin_o", o, pin_o_q & oe);
	endtask : pins
	task conclude;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	// ==============================================================
	// Watchdog, far beyond the roughly 116 cycles of the tests
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end
	// ==============================================================
	// Tests
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(2'h2, 8'hC7);
		rd(2'h3, 8'h00);
		pins(8'h00, 8'h00);
		wr(2'h1, 8'hFF);
		rd(2'h1, 8'hC7);
		wr(2'h2, 8'h00);
		wr(2'h0, 8'h41);
		rd(2'h1, 8'h41);
		pins(8'hC7, 8'h41);
		setp('{ser_on:1, spi_on:1, spi_sdo:1, default:0});
		pins(8'hC7, 8'h81);
		setp('{ser_on:1, ser_sync:1, ser_sync_dout:1, spi_on:1, spi_sdo:1,
			default:0});
		pins(8'hC7, 8'h01);
		setp('{tosc_en:1, default:0});
		pins(8'hC4, 8'h40);
		setp('{xcvr_ext:1, xcvr_oe:1, default:0});
		pins(8'hC7, 8'h43);
		chk("xcvr_in", 8'h03, {6'h00, feed_q.xcvr_minus_input, feed_q.xcvr_plus_input});
		setp('{xcvr_int_on:1, usb_drive:1, usb_dp:1, default:0});
		pins(8'hF7, 8'h61);
		setp('{pwma_on:1, pwma_out:1, cc1_on:1, default:0});
		pins(8'hC7, 8'h45);
		setp('{pwma_on:1, pwma_shut_tri:1, default:0});
		pins(8'hC3, 8'h41);
		setp('{cc2_on:1, cc2_pin_sel:1, cc2_out:1, default:0});
		pins(8'hC7, 8'h43);
		setp('{cc2_on:1, cc2_out:1, default:0});
		pins(8'hC7, 8'h41);
		setp('{cc1_on:1, cc1_out:1, default:0});
		pins(8'hC7, 8'h45);
		setp('{tosc_en:1, default:0});
		wr(2'h2, 8'hFF);
		rd(2'h2, 8'hC7);
		setp('{cc2_on:1, cc2_pin_sel:1, ser_on:1, default:0});
		ext <= 8'hA6;
		pins(8'h00, 8'h00);
		rd(2'h0, 8'hA6);
		chk("feed", 8'h07, {5'h00, feed_q.cc2_cap, feed_q.cc1_cap, feed_q.ser_rx});
		ext <= 8'h59;
		pins(8'h00, 8'h00);
		rd(2'h0, 8'h51);
		chk("feed", 8'h00, {5'h00, feed_q.cc2_cap, feed_q.cc1_cap, feed_q.ser_rx});
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'h7E);
		chk("usb_en", 8'h01, {7'h00, usb_module_enable_q});
		rd(2'h0, 8'h41);
		wr(2'h3, 8'h00);
		setp('{xcvr_int_on:1, default:0});
		pins(8'h00, 8'h00);
		rd(2'h0, 8'h41);
		setp('0);
		pins(8'h00, 8'h00);
		rd(2'h0, 8'h51);
		conclude();
	end
endmodule : pcm_port_c_bench
`default_nettype wire
